// ---- hw/cfg_bridge_regs.svh ----
/*
 * Constants of the configuration sequencer and flash bridge: boot scheme
 * codes, synchroniser slots and sequencing counts.
 * Assumes nothing; included by bare name from the design files.
 */
`ifndef CFG_BRIDGE_REGS_SVH
`define CFG_BRIDGE_REGS_SVH

// Boot scheme codes on boot_scheme_select
`define SCHEME_SERIAL_FLASH      2'h0
`define SCHEME_FAST_SERIAL_FLASH 2'h2

// Slots of the pin synchroniser vector
`define SYNC_WIDTH     10
`define SYNC_TCK       0
`define SYNC_TDI       1
`define SYNC_CHAIN_EN  2
`define SYNC_TP_ACTIVE 3
`define SYNC_TP_ERROR  4
`define SYNC_TP_DONE   5
`define SYNC_BRIDGE    6
`define SYNC_RECONFIG  7
`define SYNC_CONF_LINE 8
`define SYNC_MISO      9

// Bits read from flash during a serial-flash boot
`define BOOT_BITS      16'h0040
// Shifter phase count per flash bit (low, high, high)
`define BIT_PHASES     2'h3

`endif

// ---- hw/cfg_bridge_pkg.sv ----
/*
 * Types of the configuration sequencer and flash bridge.
 * Assumes cfg_bridge_regs.svh for the widths it names.
 */
`include "cfg_bridge_regs.svh"

package cfg_bridge_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BOOT,
        ST_TP_CFG,
        ST_INIT,
        ST_USER,
        ST_ERROR
    } seq_state_t;

    // Bit shifter state
    typedef struct packed {
        logic [1:0] phase_q;
        logic       sclk_q;
        logic       mosi_q;
        logic       rx_q;
    } shift_state_t;

endpackage

// ---- hw/flash_link_if.sv ----
/*
 * Link between the sequencer and its flash bit shifter.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/100ps

interface flash_link_if;
    logic start;    // Pulse: shift one bit
    logic tx_bit;   // Bit to send with start
    logic miso_s;   // Synchronised flash data in
    logic busy;     // Shift in progress
    logic rx_bit;   // Last bit read from flash
    logic sclk;     // Flash serial clock
    logic mosi;     // Flash serial data out

    modport seq     (output start, output tx_bit, output miso_s,
                     input busy, input rx_bit, input sclk, input mosi);
    modport shifter (input start, input tx_bit, input miso_s,
                     output busy, output rx_bit, output sclk, output mosi);
endinterface

// ---- hw/flash_shifter.sv ----
/*
 * One-bit flash shifter: sets data, raises the serial clock for two
 * cycles, samples flash data in as the clock falls.
 * Assumes start only while busy is low; miso_s already synchronised.
 */
`timescale 1ns/100ps

module flash_shifter
    import cfg_bridge_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    flash_link_if.shifter link
);

    shift_state_t s_q;  // Registered state
    shift_state_t s_d;  // Next state

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        if (link.start && s_q.phase_q == 2'h0) begin
            // Data set up while clock is low
            s_d.phase_q = `BIT_PHASES;
            s_d.mosi_q  = link.tx_bit;
            s_d.sclk_q  = 1'b0;
        end else if (s_q.phase_q != 2'h0) begin
            s_d.phase_q = s_q.phase_q - 2'h1;
            s_d.sclk_q  = (s_q.phase_q != 2'h1);
            // Capture just before the falling edge
            if (s_q.phase_q == 2'h1) begin
                s_d.rx_q = link.miso_s;
            end
        end
    end

    // Clock stays low between bits, so the flash sees an idle clock
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.busy   = (s_q.phase_q != 2'h0);
    assign link.sclk   = s_q.sclk_q;
    assign link.mosi   = s_q.mosi_q;
    assign link.rx_bit = s_q.rx_q;

endmodule // flash_shifter

// ---- hw/jtag_chain_config_flash_bridge.sv ----
/*
 * Configuration sequencer: chain enable handoff, boot arbitration between
 * test port and serial flash, and a test-port-to-flash bridge.
 * Assumes all pin inputs asynchronous to clk_sys; test port clock much
 * slower than clk_sys (at least four clk_sys periods per half cycle).
 */
//
// Overview of operation
// - Drive chain enable out low when configured
// - Chain enable in low starts own boot
// - Test port success also lowers chain out
// - Scheme 00 normal, 10 fast flash boot
// - Test port wins, aborts flash boot
// - No decompression during test port load
// - Bridge design enters user mode regardless
// - Bridge drives three flash pins, reads the fourth
// - Test port bits forwarded to flash
// - No self reconfiguration after flash write
// - Reconfiguration resets, discards bridge logic
// - Error pulls status line low
// - Success releases configuration complete line
`timescale 1ns/100ps
`include "cfg_bridge_regs.svh"

module jtag_chain_config_flash_bridge
    import cfg_bridge_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       tp_clock,                  // Test port clock pin
    input  wire logic       tp_data_in,                // Test port data in
    input  wire logic       tp_config_active,          // Test port load running
    input  wire logic       tp_config_error,           // Test port load failed
    input  wire logic       tp_config_done,            // Test port load finished
    input  wire logic       tp_reconfig_pulse,         // Reconfiguration instruction
    input  wire logic       bridge_loaded,             // Loaded design is the bridge
    input  wire logic       bridge_select,             // Host opens a flash transfer
    input  wire logic       chain_enable_in_low,
    input  wire logic [1:0] boot_scheme_select,
    input  wire logic       conf_line_in,              // Level seen on complete line
    input  wire logic       flash_serial_in,           // Data from flash
    output logic            tp_data_out,               // Flash data back to test port
    output logic            chain_enable_out_low,
    output logic            conf_line_out,
    output logic            conf_line_oe,
    output logic            error_line_out,
    output logic            error_line_oe,
    output logic            flash_serial_clock,
    output logic            flash_serial_out,
    output logic            flash_select_low,
    output logic            decompress_active,         // Decompressor in use
    output logic            user_mode
);

    // All state in one struct
    typedef struct packed {
        logic [`SYNC_WIDTH-1:0] meta_q;     // First sync stage
        logic [`SYNC_WIDTH-1:0] sync_q;     // Second sync stage
        logic                   tck_prev_q; // Test clock edge finder
        logic                   rcf_prev_q; // Reconfig edge finder
        seq_state_t             state_q;
        logic [15:0]            bits_q;     // Boot bit counter
        logic                   chain_out_q;
        logic                   conf_oe_q;
        logic                   err_oe_q;
        logic                   sel_low_q;
        logic                   tdo_q;
        logic                   start_q;
        logic                   tx_q;
    } top_state_t;

    top_state_t    s_q;        // Registered state
    top_state_t    s_d;        // Next state
    flash_link_if  link ();    // To the bit shifter
    logic [`SYNC_WIDTH-1:0] pins;    // Raw asynchronous inputs
    logic          tck_rise;   // Test clock rising edge
    logic          rcf_rise;   // Reconfig instruction edge
    logic          scheme_ok;  // Boot scheme is a flash boot

    ////////////////////////////////////////////////////////////////////
    // Pin gathering and edge finding, read only from the second stage
    always_comb begin
        pins                  = '0;
        pins[`SYNC_TCK]       = tp_clock;
        pins[`SYNC_TDI]       = tp_data_in;
        pins[`SYNC_CHAIN_EN]  = chain_enable_in_low;
        pins[`SYNC_TP_ACTIVE] = tp_config_active;
        pins[`SYNC_TP_ERROR]  = tp_config_error;
        pins[`SYNC_TP_DONE]   = tp_config_done;
        pins[`SYNC_BRIDGE]    = bridge_select;
        pins[`SYNC_RECONFIG]  = tp_reconfig_pulse;
        pins[`SYNC_CONF_LINE] = conf_line_in;
        pins[`SYNC_MISO]      = flash_serial_in;
    end

    assign tck_rise  = s_q.sync_q[`SYNC_TCK] && !s_q.tck_prev_q;
    assign rcf_rise  = s_q.sync_q[`SYNC_RECONFIG] && !s_q.rcf_prev_q;
    // Only the two flash boot codes start a boot
    assign scheme_ok = (boot_scheme_select == `SCHEME_SERIAL_FLASH) ||
                       (boot_scheme_select == `SCHEME_FAST_SERIAL_FLASH);

    ////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        s_d            = s_q;
        s_d.meta_q     = pins;
        s_d.sync_q     = s_q.meta_q;
        s_d.tck_prev_q = s_q.sync_q[`SYNC_TCK];
        s_d.rcf_prev_q = s_q.sync_q[`SYNC_RECONFIG];
        s_d.start_q    = 1'b0;
        case (s_q.state_q)
            ST_IDLE: begin
                // Test port load is taken even without chain enable
                if (s_q.sync_q[`SYNC_TP_ACTIVE]) begin
                    s_d.state_q = ST_TP_CFG;
                end else if (!s_q.sync_q[`SYNC_CHAIN_EN] && scheme_ok) begin
                    s_d.state_q   = ST_BOOT;
                    s_d.bits_q    = '0;
                    s_d.sel_low_q = 1'b0;
                end
            end
            ST_BOOT: begin
                if (s_q.sync_q[`SYNC_TP_ACTIVE]) begin
                    // Test port wins; select held until the bit on the wire ends
                    s_d.state_q   = ST_TP_CFG;
                end else if (s_q.bits_q == `BOOT_BITS) begin
                    if (!link.busy && !s_q.start_q) begin
                        s_d.state_q   = ST_INIT;
                        s_d.sel_low_q = 1'b1;
                    end
                end else if (!link.busy && !s_q.start_q) begin
                    s_d.start_q = 1'b1;
                    s_d.tx_q    = 1'b0;
                    s_d.bits_q  = s_q.bits_q + 16'h0001;
                end
            end
            ST_TP_CFG: begin
                // Image taken raw, no decompressor on this path
                s_d.sel_low_q = link.busy ? s_q.sel_low_q : 1'b1;
                if (s_q.sync_q[`SYNC_TP_ERROR]) begin
                    s_d.state_q  = ST_ERROR;
                    s_d.err_oe_q = 1'b1;
                end else if (s_q.sync_q[`SYNC_TP_DONE]) begin
                    s_d.state_q = ST_INIT;
                end
            end
            ST_INIT: begin
                s_d.conf_oe_q   = 1'b0;
                s_d.chain_out_q = 1'b0;
                // Bridge design does not wait for the shared line
                if (s_q.sync_q[`SYNC_CONF_LINE] || bridge_loaded) begin
                    s_d.state_q = ST_USER;
                end
            end
            ST_USER: begin
                // Only the instruction restarts; finishing a write does not
                if (rcf_rise) begin
                    s_d = '0;
                    s_d.meta_q    = pins;
                    s_d.sync_q    = s_q.meta_q;
                    s_d.state_q   = ST_IDLE;
                    s_d.chain_out_q = 1'b1;
                    s_d.conf_oe_q = 1'b1;
                    s_d.sel_low_q = 1'b1;
                end else if (bridge_loaded && s_q.sync_q[`SYNC_BRIDGE]) begin
                    s_d.sel_low_q = 1'b0;
                    // Each test clock rise carries one bit to flash
                    if (tck_rise && !link.busy) begin
                        s_d.start_q = 1'b1;
                        s_d.tx_q    = s_q.sync_q[`SYNC_TDI];
                        s_d.tdo_q   = link.rx_bit;
                    end
                end else begin
                    s_d.sel_low_q = (!link.busy && !s_q.start_q) ? 1'b1 : s_q.sel_low_q;
                end
            end
            ST_ERROR: begin
                // Stays in error until the host restarts the device
                if (rcf_rise) begin
                    s_d.state_q  = ST_IDLE;
                    s_d.err_oe_q = 1'b0;
                end
            end
            default: begin
                s_d.state_q = ST_IDLE;
            end
        endcase
    end

    // Register the whole state; chain enable syncs start inactive, no false boot
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q             <= '0;
            s_q.state_q     <= ST_IDLE;
            s_q.chain_out_q <= 1'b1;
            s_q.conf_oe_q   <= 1'b1;
            s_q.sel_low_q   <= 1'b1;
            s_q.meta_q[`SYNC_CHAIN_EN] <= 1'b1;
            s_q.sync_q[`SYNC_CHAIN_EN] <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bit shifter
    assign link.start  = s_q.start_q;
    assign link.tx_bit = s_q.tx_q;
    assign link.miso_s = s_q.sync_q[`SYNC_MISO];

    flash_shifter u_shifter (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .link    (link)
    );

    // Outputs
    assign tp_data_out          = s_q.tdo_q;
    assign chain_enable_out_low = s_q.chain_out_q;
    assign conf_line_out        = 1'b0;
    assign conf_line_oe         = s_q.conf_oe_q;
    assign error_line_out       = 1'b0;
    assign error_line_oe        = s_q.err_oe_q;
    assign flash_serial_clock   = link.sclk;
    assign flash_serial_out     = link.mosi;
    assign flash_select_low     = s_q.sel_low_q;
    assign decompress_active    = (s_q.state_q == ST_BOOT);
    assign user_mode            = (s_q.state_q == ST_USER);

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_chain_out;
        (s_q.state_q == ST_USER) |-> !chain_enable_out_low;
    endproperty
    a_chain_out: assert property (p_chain_out) else $error("chain out not low in user mode");

    property p_boot_start;
        (s_q.state_q == ST_IDLE && !s_q.sync_q[`SYNC_CHAIN_EN] && scheme_ok && !s_q.sync_q[`SYNC_TP_ACTIVE])
            |=> (s_q.state_q == ST_BOOT);
    endproperty
    a_boot_start: assert property (p_boot_start) else $error("boot did not start");

    property p_tp_done;
        (s_q.state_q == ST_TP_CFG && s_q.sync_q[`SYNC_TP_DONE] && !s_q.sync_q[`SYNC_TP_ERROR])
            |=> ##1 (!chain_enable_out_low && !conf_line_oe);
    endproperty
    a_tp_done: assert property (p_tp_done) else $error("success not signalled");

    property p_abort;
        (s_q.state_q == ST_BOOT && s_q.sync_q[`SYNC_TP_ACTIVE])
            |=> (s_q.state_q == ST_TP_CFG) ##[0:5] flash_select_low;
    endproperty
    a_abort: assert property (p_abort) else $error("flash boot not aborted");

    property p_no_decomp;
        (s_q.state_q == ST_TP_CFG) |-> !decompress_active;
    endproperty
    a_no_decomp: assert property (p_no_decomp) else $error("decompressor on in test port load");

    property p_bridge_user;
        (s_q.state_q == ST_INIT && bridge_loaded) |=> user_mode;
    endproperty
    a_bridge_user: assert property (p_bridge_user) else $error("bridge did not enter user mode");

    property p_fwd;
        (user_mode && bridge_loaded && s_q.sync_q[`SYNC_BRIDGE] && tck_rise && !link.busy
            && !rcf_rise) |=> ##1 (flash_serial_out == $past(s_q.sync_q[`SYNC_TDI], 2)) ##1 flash_serial_clock;
    endproperty
    a_fwd: assert property (p_fwd) else $error("bit not forwarded");

    property p_stay;
        (user_mode && !rcf_rise) |=> user_mode;
    endproperty
    a_stay: assert property (p_stay) else $error("left user mode on its own");

    property p_error;
        (s_q.state_q == ST_TP_CFG && s_q.sync_q[`SYNC_TP_ERROR]) |=> error_line_oe;
    endproperty
    a_error: assert property (p_error) else $error("error not signalled");

    property p_idle_flash;
        (flash_select_low) |-> !flash_serial_clock;
    endproperty
    a_idle_flash: assert property (p_idle_flash) else $error("flash clock runs while deselected");

    c_boot: cover property (s_q.state_q == ST_BOOT ##1 s_q.state_q == ST_INIT);
    c_tp:   cover property (s_q.state_q == ST_TP_CFG ##1 s_q.state_q == ST_INIT);
    c_fwd:  cover property (user_mode && link.start);
    c_rst:  cover property (user_mode ##1 s_q.state_q == ST_IDLE);

endmodule // jtag_chain_config_flash_bridge

// ---- testbench/flash_partner.sv ----
/*
 * Behavioural serial flash at the far side of the bridge: takes data on
 * the rising serial clock while selected and answers with a chosen level.
 * Assumes the bench sets reply_level between transfers only.
 */
`timescale 1ns/100ps

module flash_partner (
    input  wire logic flash_serial_clock,  // Serial clock from the bridge
    input  wire logic flash_serial_out,    // Data written by the bridge
    input  wire logic flash_select_low,    // Select, active low
    input  wire logic reply_level,         // Level answered while selected
    output logic      flash_serial_in      // Data back to the bridge
);

    logic [7:0] rx_shift_q;  // Last bits written, newest in bit 0

    ////////////////////////////////////////////////////////////////////////
    // Write side: data taken on rising clock only while selected
    initial begin
        rx_shift_q = 8'h00;
        flash_serial_in = 1'b0;
    end

    always @(posedge flash_serial_clock) begin
        if (flash_select_low === 1'b0) begin
            rx_shift_q <= {rx_shift_q[6:0], flash_serial_out};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read side: released line toggles, so a stale value never passes
    always begin
        #50;
        if (flash_select_low === 1'b0) begin
            flash_serial_in = reply_level;
        end else begin
            flash_serial_in = ~flash_serial_in;
        end
    end

endmodule // flash_partner

// ---- testbench/jtag_chain_config_flash_bridge_tb_top.sv ----
/*
 * Self-checking bench of the configuration sequencer and flash bridge.
 * Assumes the flash partner model and the design files are compiled first.
 */
`timescale 1ns/100ps
`include "cfg_bridge_regs.svh"

module jtag_chain_config_flash_bridge_tb_top;

    localparam int IX_DEC = 0;  // Status slots of st
    localparam int IX_USER = 1;
    localparam int IX_CONF = 2;
    localparam int IX_ERR = 3;
    localparam int IX_CHAIN = 4;
    localparam int IX_SEL = 5;

    logic       clk_sys, reset_n, tp_clock, tp_data_in;
    logic       tp_config_active, tp_config_error, tp_config_done;
    logic       tp_reconfig_pulse, bridge_loaded, bridge_select;
    logic       chain_enable_in_low, others_low, reply_level;
    logic [1:0] boot_scheme_select;
    logic       tp_data_out, chain_enable_out_low, conf_line_out, conf_line_oe;
    logic       error_line_out, error_line_oe, flash_serial_clock;
    logic       flash_serial_out, flash_select_low, flash_serial_in;
    logic       decompress_active, user_mode;
    wire        conf_line_in;  // Pulled-up shared complete line
    wire  [5:0] st;            // Status bits watched by the waits
    int         err_count, n_tests, n_boot, n_sclk;
    logic       exp_q[$];      // Bits the host expects at the flash

    // Open drain: low if we drive it or an unconfigured slave holds it
    assign conf_line_in = (conf_line_oe === 1'b1) ? conf_line_out : !others_low;
    assign st = {flash_select_low, chain_enable_out_low, error_line_oe,
                 conf_line_oe, user_mode, decompress_active};

    jtag_chain_config_flash_bridge u_jtag_chain_config_flash_bridge (
        .clk_sys(clk_sys), .reset_n(reset_n), .tp_clock(tp_clock), .tp_data_in(tp_data_in),
        .tp_config_active(tp_config_active), .tp_config_error(tp_config_error),
        .tp_config_done(tp_config_done), .tp_reconfig_pulse(tp_reconfig_pulse),
        .bridge_loaded(bridge_loaded), .bridge_select(bridge_select),
        .chain_enable_in_low(chain_enable_in_low), .boot_scheme_select(boot_scheme_select),
        .conf_line_in(conf_line_in), .flash_serial_in(flash_serial_in), .tp_data_out(tp_data_out),
        .chain_enable_out_low(chain_enable_out_low), .conf_line_out(conf_line_out),
        .conf_line_oe(conf_line_oe), .error_line_out(error_line_out), .error_line_oe(error_line_oe),
        .flash_serial_clock(flash_serial_clock), .flash_serial_out(flash_serial_out),
        .flash_select_low(flash_select_low), .decompress_active(decompress_active),
        .user_mode(user_mode));

    flash_partner u_flash_partner (
        .flash_serial_clock(flash_serial_clock), .flash_serial_out(flash_serial_out),
        .flash_select_low(flash_select_low), .reply_level(reply_level),
        .flash_serial_in(flash_serial_in));

    ////////////////////////////////////////////////////////////////////////
    // Clock: 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Bounded wait; running out ends the run
    task automatic wait_st(input int idx, input logic val, input int limit);
        int k;
        k = 0;
        while (st[idx] !== val && k < limit) begin
            tick(1);
            k++;
        end
        chk("status bit wait", 8'(val), 8'(st[idx]));
        if (st[idx] !== val) give_verdict();
    endtask

    // Inputs back to idle, reset held n cycles, then syncs flushed
    task automatic rst(input int n);
        reset_n = 1'b0;
        {tp_clock, tp_data_in, tp_config_active, tp_config_error, tp_config_done} = '0;
        {tp_reconfig_pulse, bridge_loaded, bridge_select, others_low} = '0;
        chain_enable_in_low = 1'b1;
        tick(n);
        reset_n = 1'b1;
        tick(4);
    endtask

    // One host bit over the link, 800 ns period; expectation noted first
    task automatic send_bit(input logic b);
        tp_data_in = b;
        exp_q.push_back(b);
        #200 tp_clock = 1'b1;
        #400 tp_clock = 1'b0;
        #200;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Flash-side watcher: boot clocks counted, bridge bits compared in order
    always @(posedge flash_serial_clock) begin
        n_sclk++;
        if (user_mode === 1'b1 && flash_select_low === 1'b0) begin
            if (exp_q.size() == 0) begin
                chk("unexpected flash bit", 8'h00, 8'h01);
            end else begin
                chk("flash data bit", 8'(exp_q.pop_front()), 8'(flash_serial_out));
            end
        end else if (flash_select_low === 1'b0 && decompress_active === 1'b1) begin
            n_boot++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h26B1));
        {err_count, n_tests, n_boot, n_sclk} = '0;
        boot_scheme_select = 2'h0;
        reply_level = 1'b0;
        rst(20);
        chk("reset outputs", 8'h34, 8'(st));
        chk("serial clock idle", 8'h00, 8'(flash_serial_clock));
        // Every scheme code; only 00 and 10 may boot from flash
        for (int s = 0; s < 4; s++) begin
            boot_scheme_select = 2'(s);
            rst(4);
            n_boot = 0;
            chain_enable_in_low = 1'b0;
            if (s == 0 || s == 2) begin
                wait_st(IX_DEC, 1'b1, 20);
                wait_st(IX_DEC, 1'b0, 2000);
                tick(3);
                chk("boot bit count", 8'(`BOOT_BITS), 8'(n_boot));
                wait_st(IX_CHAIN, 1'b0, 4);
                wait_st(IX_USER, 1'b1, 20);
            end else begin
                tick(100);
                chk("no boot for scheme", 8'h20, 8'(st & 6'h21));
            end
        end
        // Test port load arrives in mid boot and wins
        boot_scheme_select = 2'h2;
        rst(4);
        chain_enable_in_low = 1'b0;
        wait_st(IX_DEC, 1'b1, 20);
        tick($urandom_range(60, 5));
        tp_config_active = 1'b1;
        wait_st(IX_DEC, 1'b0, 8);
        wait_st(IX_SEL, 1'b1, 8);
        tick(20);
        chk("no decompress in test port load", 8'h00, 8'(decompress_active));
        tp_config_done = 1'b1;
        wait_st(IX_CHAIN, 1'b0, 8);
        wait_st(IX_CONF, 1'b0, 2);
        wait_st(IX_USER, 1'b1, 8);
        // Failed test port load, then leaving the error state
        rst(4);
        tp_config_active = 1'b1;
        tick(10);
        tp_config_error = 1'b1;
        wait_st(IX_ERR, 1'b1, 8);
        chk("no user mode on error", 8'h00, 8'(user_mode));
        {tp_config_active, tp_config_error} = '0;
        tick(4);
        tp_reconfig_pulse = 1'b1;
        wait_st(IX_ERR, 1'b0, 8);
        // Bridge loaded while slaves hold the complete line low
        rst(4);
        {others_low, bridge_loaded, tp_config_active} = 3'h7;
        tick(10);
        tp_config_done = 1'b1;
        wait_st(IX_USER, 1'b1, 12);
        {tp_config_active, tp_config_done} = '0;
        for (int r = 1; r >= 0; r--) begin
            reply_level = 1'(r);
            bridge_select = 1'b1;
            wait_st(IX_SEL, 1'b0, 8);
            #37;
            repeat (8) send_bit(1'($urandom));
            tp_data_in = ~tp_data_in;
            tick(10);
            chk("flash bits all forwarded", 8'h00, 8'(exp_q.size()));
            chk("flash reply to host", 8'(r), 8'(tp_data_out));
            bridge_select = 1'b0;
            wait_st(IX_SEL, 1'b1, 8);
        end
        // Written flash: device must sit still until told
        n_sclk = 0;
        tick(300);
        chk("stays in user mode", 8'h22, 8'(st));
        chk("serial clock quiet", 8'h00, 8'(n_sclk));
        tp_reconfig_pulse = 1'b1;
        wait_st(IX_USER, 1'b0, 8);
        tick(2);
        chk("reset state after reconfig", 8'h34, 8'(st));
        give_verdict();
    end

endmodule // jtag_chain_config_flash_bridge_tb_top
